// ==== sim/rtb_top_properties.sv ====
// Port-level checker for the reader timer bank
`timescale 1ns/1ps
`default_nettype none

module rtb_top_chk (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // APB side
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // Interrupt
   input wire logic irq_out
);
   // ======
   // Helpers: finished reads, accesses that may lower the interrupt
   wire logic rd_done = pready_out && !pwrite_in;
   wire logic irq_acc = pready_out && (paddr_in == 8'h80 || paddr_in == 8'h84);
   wire logic mapped = paddr_in[1:0] == 2'h0 && paddr_in[7:2] >= 6'h12 && paddr_in[7:2] <= 6'h19;

   // One clock domain, so clocking and disable are shared
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   // ======
   // Bus timing and answers
   property p_ready_late; $rose(penable_in) && psel_in |-> !pready_out ##1 pready_out; endproperty
   a_ready_late: assert property (p_ready_late) else $error("pready not in second access cycle");
   property p_ready_pulse; pready_out |=> !pready_out; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_ready_req; pready_out |-> psel_in && penable_in; endproperty
   a_ready_req: assert property (p_ready_req) else $error("pready without access phase");
   property p_err_align; pready_out && paddr_in[1:0] != 2'h0 |-> pslverr_out; endproperty
   a_err_align: assert property (p_err_align) else $error("unaligned access not refused");
   property p_no_err; pready_out && mapped |-> !pslverr_out; endproperty
   a_no_err: assert property (p_no_err) else $error("timer register refused");
   property p_hi_zero; rd_done |-> prdata_out[31:8] == 24'h0; endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("read data above byte not zero");

   // ======
   // Reserved setup bits and interrupt release
   property p_t1_rsvd; rd_done && paddr_in == 8'h50 |-> !prdata_out[6] && !prdata_out[2]; endproperty
   a_t1_rsvd: assert property (p_t1_rsvd) else $error("timer1 reserved bits not zero");
   property p_t2_rsvd; rd_done && paddr_in == 8'h64 |-> !prdata_out[6] && !prdata_out[2]; endproperty
   a_t2_rsvd: assert property (p_t2_rsvd) else $error("timer2 reserved bits not zero");
   property p_irq_fall; $fell(irq_out) |-> $past(irq_acc) || $past(irq_acc, 2); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without clear");
endmodule // rtb_top_chk

bind rtb_top rtb_top_chk u_chk (.core_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
   .prdata_out, .pready_out, .pslverr_out, .irq_out);

`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the reader timer bank
`timescale 1ns/1ps
`default_nettype none
`include "rtb_consts.svh"

module tb;
   // Design-facing signals; the inputs are all set at time zero
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [2:0] ev = 3'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [31:0] rd_val;
   logic rd_err;
   logic [31:0] v;
   int num_errors = 0;
   int samples_checked = 0;

   // ======
   // Clock and design
   always #4 clk = ~clk;
   rtb_top u_rtb_top (.core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .tx_end_in(ev[0]), .rx_first_bits_in(ev[1]), .low_freq_oscillator_in(ev[2]),
      .irq_out(irq));

   // ======
   // Comparison and verdict
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ======
   // APB master; an idle cycle follows so no signal is set twice at one edge
   task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      // No cycle limit here; only the watchdog ends a hung access
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd_val = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      xfer(1'b1, i, d);
   endtask
   task automatic rd(input string w, input logic [5:0] i, input logic [31:0] e);
      xfer(1'b0, i, 8'h00);
      chk(w, e, rd_val);
   endtask

   // ======
   // Event pulses and bounded interrupt wait
   task automatic pulse(input logic [2:0] m);
      ev <= m;
      @(posedge clk);
      ev <= 3'h0;
      @(posedge clk);
   endtask
   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk("irq", 32'h1, {31'h0, irq});
   endtask

   // Hang guard, far above the 600 or so cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      close_out();
   end

   // ======
   // Tests
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd("t1_setup", `RTB_IDX_T1_SETUP, 32'h0);
      rd("t0_count_high", `RTB_IDX_T0_COUNT_HI, 32'h0);
      rd("t0_count_low", `RTB_IDX_T0_COUNT_LO, 32'h0);
      wr(`RTB_IDX_T1_SETUP, 8'hFF);
      rd("t1_setup", `RTB_IDX_T1_SETUP, 32'hBB);
      wr(`RTB_IDX_T2_SETUP, 8'hFF);
      rd("t2_setup", `RTB_IDX_T2_SETUP, 32'hBB);
      wr(`RTB_IDX_T1_RELOAD_HI, 8'hA5);
      rd("t1_reload_high", `RTB_IDX_T1_RELOAD_HI, 32'hA5);
      wr(`RTB_IDX_T1_RELOAD_LO, 8'h5A);
      rd("t1_reload_low", `RTB_IDX_T1_RELOAD_LO, 32'h5A);
      wr(`RTB_IDX_T1_COUNT_LO, 8'h77);
      rd("t1_count_low", `RTB_IDX_T1_COUNT_LO, 32'h0);
      xfer(1'b0, 6'h3F, 8'h00);
      chk("unmapped_err", 32'h1, {31'h0, rd_err});
      $display("test registers done");
      // One-shot from end of transmission; reload changed mid-run
      wr(`RTB_IDX_IRQ_MASK, 8'h02);
      wr(`RTB_IDX_T1_RELOAD_HI, 8'h00);
      wr(`RTB_IDX_T1_RELOAD_LO, 8'h03);
      wr(`RTB_IDX_T1_SETUP, 8'h10);
      pulse(3'b001);
      wr(`RTB_IDX_T1_RELOAD_LO, 8'hFF);
      wait_irq(80);
      rd("t1_count_high", `RTB_IDX_T1_COUNT_HI, 32'h0);
      rd("t1_count_low", `RTB_IDX_T1_COUNT_LO, 32'h0);
      rd("irq_status", `RTB_IDX_IRQ_STATUS, 32'h2);
      repeat (3) @(posedge clk);
      chk("irq_cleared", 32'h0, {31'h0, irq});
      pulse(3'b001);
      rd("t1_count_high", `RTB_IDX_T1_COUNT_HI, 32'h0);
      xfer(1'b0, `RTB_IDX_T1_COUNT_LO, 8'h00);
      chk("t1_count_low_top", 32'hF, {28'h0, rd_val[7:4]});
      $display("test one_shot done");
      // Manual mode ignores end of transmission; run control masked writes
      wr(`RTB_IDX_RUN_CTRL, 8'h02);
      rd("run_ctrl", `RTB_IDX_RUN_CTRL, 32'h0);
      wr(`RTB_IDX_T1_SETUP, 8'h00);
      xfer(1'b0, `RTB_IDX_T1_COUNT_LO, 8'h00);
      v = rd_val;
      pulse(3'b001);
      repeat (30) @(posedge clk);
      rd("t1_count_low", `RTB_IDX_T1_COUNT_LO, v);
      wr(`RTB_IDX_RUN_CTRL, 8'h22);
      rd("run_ctrl", `RTB_IDX_RUN_CTRL, 32'h20);
      wr(`RTB_IDX_RUN_CTRL, 8'h02);
      rd("run_ctrl", `RTB_IDX_RUN_CTRL, 32'h0);
      $display("test manual done");
      // Auto reload keeps underflowing
      wr(`RTB_IDX_T1_RELOAD_LO, 8'h03);
      wr(`RTB_IDX_T1_SETUP, 8'h18);
      pulse(3'b001);
      wait_irq(80);
      rd("irq_status", `RTB_IDX_IRQ_STATUS, 32'h2);
      repeat (3) @(posedge clk);
      wait_irq(80);
      wr(`RTB_IDX_IRQ_MASK, 8'h00);
      repeat (3) @(posedge clk);
      chk("irq_masked", 32'h0, {31'h0, irq});
      wr(`RTB_IDX_RUN_CTRL, 8'h02);
      xfer(1'b0, `RTB_IDX_IRQ_STATUS, 8'h00);
      $display("test auto_reload done");
      // Halt on receive; the count then holds while stopped
      wr(`RTB_IDX_T1_RELOAD_HI, 8'h01);
      wr(`RTB_IDX_T1_SETUP, 8'h90);
      pulse(3'b001);
      repeat (20) @(posedge clk);
      pulse(3'b010);
      rd("run_ctrl", `RTB_IDX_RUN_CTRL, 32'h0);
      xfer(1'b0, `RTB_IDX_T1_COUNT_LO, 8'h00);
      v = rd_val;
      repeat (40) @(posedge clk);
      rd("t1_count_low", `RTB_IDX_T1_COUNT_LO, v);
      $display("test halt done");
      // Trimming mode: receive ignored, oscillator edges start and stop; Timer2 still trims too
      wr(`RTB_IDX_T1_SETUP, 8'hA0);
      pulse(3'b100);
      pulse(3'b010);
      repeat (30) @(posedge clk);
      rd("run_ctrl", `RTB_IDX_RUN_CTRL, 32'h60);
      pulse(3'b100);
      rd("run_ctrl", `RTB_IDX_RUN_CTRL, 32'h0);
      $display("test trimming done");
      // Cascade: Timer1 steps only on Timer0 underflows
      wr(`RTB_IDX_T0_RELOAD_LO, 8'h01);
      wr(`RTB_IDX_T0_SETUP, 8'h08);
      wr(`RTB_IDX_T1_RELOAD_HI, 8'h00);
      wr(`RTB_IDX_T1_SETUP, 8'h02);
      wr(`RTB_IDX_IRQ_MASK, 8'h02);
      wr(`RTB_IDX_RUN_CTRL, 8'h22);
      repeat (60) @(posedge clk);
      rd("t1_count_low", `RTB_IDX_T1_COUNT_LO, 32'h3);
      wr(`RTB_IDX_RUN_CTRL, 8'h11);
      wait_irq(150);
      rd("irq_status", `RTB_IDX_IRQ_STATUS, 32'h3);
      wr(`RTB_IDX_RUN_CTRL, 8'h01);
      $display("test cascade done");
      close_out();
   end
endmodule // tb

`default_nettype wire

// ==== src/rtb_consts.svh ====
// Register indices, field positions, reset values and rates of the reader timer bank
`ifndef RTB_CONSTS_SVH
`define RTB_CONSTS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define RTB_IDX_RUN_CTRL 6'h0E
`define RTB_IDX_T0_SETUP 6'h0F
`define RTB_IDX_T0_RELOAD_HI 6'h10
`define RTB_IDX_T0_RELOAD_LO 6'h11
`define RTB_IDX_T0_COUNT_HI 6'h12
`define RTB_IDX_T0_COUNT_LO 6'h13
`define RTB_IDX_T1_SETUP 6'h14
`define RTB_IDX_T1_RELOAD_HI 6'h15
`define RTB_IDX_T1_RELOAD_LO 6'h16
`define RTB_IDX_T1_COUNT_HI 6'h17
`define RTB_IDX_T1_COUNT_LO 6'h18
`define RTB_IDX_T2_SETUP 6'h19
`define RTB_IDX_T2_RELOAD_HI 6'h1A
`define RTB_IDX_T2_RELOAD_LO 6'h1B
`define RTB_IDX_T2_COUNT_HI 6'h1C
`define RTB_IDX_T2_COUNT_LO 6'h1D
`define RTB_IDX_IRQ_STATUS 6'h20
`define RTB_IDX_IRQ_MASK 6'h21

// ==========================================================
// Setup and run control register fields
`define RTB_HALT_BIT 7
`define RTB_MODE_HI 5
`define RTB_MODE_LO 4
`define RTB_AUTO_BIT 3
`define RTB_CLK_HI 1
`define RTB_CLK_LO 0
`define RTB_SETUP_WMASK 8'hBB
`define RTB_RUN_SHIFT 4

// ==========================================================
// Reset values
`define RTB_SETUP_RESET 8'h00
`define RTB_RELOAD_RESET 8'h00
`define RTB_MASK_RESET 3'h0

// ==========================================================
// Rates in Hz: core clock and the two fixed count clocks
`define RTB_CORE_HZ 125000000
`define RTB_FAST_HZ 13560000
`define RTB_SLOW_HZ 211875

`endif

// ==== src/rtb_pkg.sv ====
// Types shared by the reader timer bank modules
package rtb_pkg;

   // ==========================================================
   // Start mode field encodings
   typedef enum logic [1:0] {
      RTB_START_MANUAL = 2'b00,
      RTB_START_TX_END = 2'b01,
      RTB_START_TRIM = 2'b10,
      RTB_START_TRIM_UFL = 2'b11
   } rtb_start_mode_t;

   // ==========================================================
   // Clock select field encodings
   typedef enum logic [1:0] {
      RTB_CLK_FAST = 2'b00,
      RTB_CLK_SLOW = 2'b01,
      RTB_CLK_CASC_A = 2'b10,
      RTB_CLK_CASC_B = 2'b11
   } rtb_clk_sel_t;

   // ==========================================================
   // Channel and bus slave states
   typedef enum logic {
      RTB_STOPPED = 1'b0,
      RTB_RUNNING = 1'b1
   } rtb_run_state_t;

   typedef enum logic {
      RTB_APB_IDLE = 1'b0,
      RTB_APB_ANSWER = 1'b1
   } rtb_apb_state_t;

endpackage

// ==== src/rtb_tick_gen.sv ====
// Fractional rate generator: one-cycle ticks at OUT_HZ from the core clock
`timescale 1ns/1ps
`default_nettype none
`include "rtb_consts.svh"

module rtb_tick_gen #(
   parameter int unsigned CORE_HZ = `RTB_CORE_HZ,
   parameter int unsigned OUT_HZ = `RTB_FAST_HZ
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Tick
   output logic tick_out
);
   localparam logic [31:0] STEP = 32'(OUT_HZ);
   localparam logic [31:0] WRAP = 32'(CORE_HZ);

   logic [31:0] acc;
   logic [31:0] sum;

   // Phase accumulator; jitter of one core cycle is traded for an exact mean rate
   assign sum = acc + STEP;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         acc <= 32'h0;
         tick_out <= 1'b0;
      end else if (sum >= WRAP) begin
         acc <= sum - WRAP;
         tick_out <= 1'b1;
      end else begin
         acc <= sum;
         tick_out <= 1'b0;
      end
   end
endmodule // rtb_tick_gen

`default_nettype wire

// ==== src/rtb_timer.sv ====
// One 16-bit down-counting timer channel
`timescale 1ns/1ps
`default_nettype none
`include "rtb_consts.svh"

module rtb_timer (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Control and status bundle
   rtb_timer_if.chan tif
);
   rtb_pkg::rtb_run_state_t state;
   rtb_pkg::rtb_run_state_t next_state;
   rtb_pkg::rtb_start_mode_t mode;
   logic trim;
   logic halt;
   logic reload_on_zero;
   logic at_zero;
   logic wrap_evt;
   logic start_evt;
   logic stop_evt;

   // ==========================================================
   // Field decode and events
   assign mode = rtb_pkg::rtb_start_mode_t'(tif.setup[`RTB_MODE_HI:`RTB_MODE_LO]);
   assign trim = (mode == rtb_pkg::RTB_START_TRIM) || (mode == rtb_pkg::RTB_START_TRIM_UFL);
   assign halt = tif.setup[`RTB_HALT_BIT] && !trim;
   // Trimming without underflow never reloads on zero
   assign reload_on_zero = tif.setup[`RTB_AUTO_BIT] && (mode != rtb_pkg::RTB_START_TRIM);
   assign at_zero = (tif.count == 16'h0000);
   assign wrap_evt = (state == rtb_pkg::RTB_RUNNING) && tif.tick && at_zero;
   assign start_evt = (state == rtb_pkg::RTB_STOPPED) &&
      (tif.sw_start ||
       ((mode == rtb_pkg::RTB_START_TX_END) && tif.tx_end) ||
       (trim && tif.lfo_rise));
   assign stop_evt = (state == rtb_pkg::RTB_RUNNING) &&
      (tif.sw_stop ||
       (halt && tif.rx_first) ||
       (trim && tif.lfo_rise));
   assign tif.running = (state == rtb_pkg::RTB_RUNNING);

   // Run state machine
   always_comb begin
      next_state = state;
      case (state)
         rtb_pkg::RTB_STOPPED: begin
            if (start_evt) begin
               next_state = rtb_pkg::RTB_RUNNING;
            end
         end
         rtb_pkg::RTB_RUNNING: begin
            if (stop_evt) begin
               next_state = rtb_pkg::RTB_STOPPED;
            end else if (wrap_evt && !reload_on_zero) begin
               next_state = rtb_pkg::RTB_STOPPED;
            end
         end
         default: next_state = rtb_pkg::RTB_STOPPED;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= rtb_pkg::RTB_STOPPED;
      end else begin
         state <= next_state;
      end
   end

   // Counter: reload is sampled only at a start or a wrap
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tif.count <= 16'h0000;
      end else if (start_evt) begin
         tif.count <= tif.reload;
      end else if ((state == rtb_pkg::RTB_RUNNING) && !stop_evt && tif.tick) begin
         if (!at_zero) begin
            tif.count <= 16'(tif.count - 16'h0001);
         end else if (reload_on_zero) begin
            tif.count <= tif.reload;
         end
      end
   end

   // One-cycle underflow pulse, suppressed in trimming without underflow
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tif.underflow <= 1'b0;
      end else begin
         tif.underflow <= wrap_evt && !stop_evt && (mode != rtb_pkg::RTB_START_TRIM);
      end
   end
endmodule // rtb_timer

`default_nettype wire

// ==== src/rtb_timer_if.sv ====
// Bundle between the register block and one timer channel
`timescale 1ns/1ps
`default_nettype none

interface rtb_timer_if;
   logic [7:0] setup;
   logic [15:0] reload;
   logic sw_start;
   logic sw_stop;
   logic tick;
   logic tx_end;
   logic rx_first;
   logic lfo_rise;
   logic [15:0] count;
   logic running;
   logic underflow;

   modport ctrl (
      output setup, reload, sw_start, sw_stop, tick, tx_end, rx_first, lfo_rise,
      input count, running, underflow
   );
   modport chan (
      input setup, reload, sw_start, sw_stop, tick, tx_end, rx_first, lfo_rise,
      output count, running, underflow
   );
endinterface

`default_nettype wire

// ==== src/rtb_top.sv ====
// Reader timer bank: three cascadable down-counting timers behind an APB slave
`timescale 1ns/1ps
`default_nettype none
`include "rtb_consts.svh"

module rtb_top (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Transceiver events
   input wire logic tx_end_in,
   input wire logic rx_first_bits_in,
   input wire logic low_freq_oscillator_in,
   // Interrupt
   output logic irq_out
);
   // ==========================================================
   // Reset release
   logic rst_meta_n;
   logic rst_sync_n;

   // Assert at once, release through two flops to avoid recovery hazards
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // ==========================================================
   // Declarations
   rtb_pkg::rtb_apb_state_t apb_state;
   logic [7:0] setup_reg [3];
   logic [7:0] reload_hi [3];
   logic [7:0] reload_lo [3];
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [2:0] status_taken;
   logic [2:0] uflow;
   logic [2:0] run_now;
   logic [2:0] sw_start_v;
   logic [2:0] sw_stop_v;
   logic [15:0] count_v [3];
   logic fast_tick;
   logic slow_tick;
   logic lfo_q;
   logic lfo_rise;
   logic [5:0] idx;
   logic aligned;
   logic hit;
   logic [7:0] rd_byte;
   logic access;
   logic wr_fire;
   logic rd_fire;

   rtb_timer_if tif0();
   rtb_timer_if tif1();
   rtb_timer_if tif2();

   // ==========================================================
   // Functions
   // Select the count tick from the two clocks or one of two cascades
   function automatic logic pick_tick(input logic [1:0] sel, input logic fast, input logic slow,
                                      input logic casc_a, input logic casc_b);
      logic res;
      res = fast;
      case (rtb_pkg::rtb_clk_sel_t'(sel))
         rtb_pkg::RTB_CLK_FAST: res = fast;
         rtb_pkg::RTB_CLK_SLOW: res = slow;
         rtb_pkg::RTB_CLK_CASC_A: res = casc_a;
         rtb_pkg::RTB_CLK_CASC_B: res = casc_b;
         default: res = fast;
      endcase
      return res;
   endfunction

   // True for every index that the slave answers
   function automatic logic index_known(input logic [5:0] i);
      logic res;
      res = ((i >= `RTB_IDX_RUN_CTRL) && (i <= `RTB_IDX_T2_COUNT_LO)) ||
            (i == `RTB_IDX_IRQ_STATUS) || (i == `RTB_IDX_IRQ_MASK);
      return res;
   endfunction

   // ==========================================================
   // Count clocks
   rtb_tick_gen #(
      .CORE_HZ(`RTB_CORE_HZ),
      .OUT_HZ(`RTB_FAST_HZ)
   ) u_fast_tick (
      .clk_in(core_clk_in),
      .rst_n_in(rst_sync_n),
      .tick_out(fast_tick)
   );

   rtb_tick_gen #(
      .CORE_HZ(`RTB_CORE_HZ),
      .OUT_HZ(`RTB_SLOW_HZ)
   ) u_slow_tick (
      .clk_in(core_clk_in),
      .rst_n_in(rst_sync_n),
      .tick_out(slow_tick)
   );

   // Oscillator edge detect; input is already synchronous
   always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         lfo_q <= 1'b0;
      end else begin
         lfo_q <= low_freq_oscillator_in;
      end
   end
   assign lfo_rise = low_freq_oscillator_in && !lfo_q;

   // ==========================================================
   // Timer channels
   assign uflow = {tif2.underflow, tif1.underflow, tif0.underflow};
   assign run_now = {tif2.running, tif1.running, tif0.running};
   assign count_v[0] = tif0.count;
   assign count_v[1] = tif1.count;
   assign count_v[2] = tif2.count;

   // Channel 0 bundle; cascades from Timer2 then Timer1
   assign tif0.setup = setup_reg[0];
   assign tif0.reload = {reload_hi[0], reload_lo[0]};
   assign tif0.sw_start = sw_start_v[0];
   assign tif0.sw_stop = sw_stop_v[0];
   assign tif0.tick = pick_tick(setup_reg[0][`RTB_CLK_HI:`RTB_CLK_LO], fast_tick, slow_tick, uflow[2], uflow[1]);
   assign tif0.tx_end = tx_end_in;
   assign tif0.rx_first = rx_first_bits_in;
   assign tif0.lfo_rise = lfo_rise;

   // Channel 1 bundle; cascades from Timer0 then Timer2
   assign tif1.setup = setup_reg[1];
   assign tif1.reload = {reload_hi[1], reload_lo[1]};
   assign tif1.sw_start = sw_start_v[1];
   assign tif1.sw_stop = sw_stop_v[1];
   assign tif1.tick = pick_tick(setup_reg[1][`RTB_CLK_HI:`RTB_CLK_LO], fast_tick, slow_tick, uflow[0], uflow[2]);
   assign tif1.tx_end = tx_end_in;
   assign tif1.rx_first = rx_first_bits_in;
   assign tif1.lfo_rise = lfo_rise;

   // Channel 2 bundle; cascades from Timer0 then Timer1
   assign tif2.setup = setup_reg[2];
   assign tif2.reload = {reload_hi[2], reload_lo[2]};
   assign tif2.sw_start = sw_start_v[2];
   assign tif2.sw_stop = sw_stop_v[2];
   assign tif2.tick = pick_tick(setup_reg[2][`RTB_CLK_HI:`RTB_CLK_LO], fast_tick, slow_tick, uflow[0], uflow[1]);
   assign tif2.tx_end = tx_end_in;
   assign tif2.rx_first = rx_first_bits_in;
   assign tif2.lfo_rise = lfo_rise;

   rtb_timer u_timer0 (
      .clk_in(core_clk_in),
      .rst_n_in(rst_sync_n),
      .tif(tif0.chan)
   );

   rtb_timer u_timer1 (
      .clk_in(core_clk_in),
      .rst_n_in(rst_sync_n),
      .tif(tif1.chan)
   );

   rtb_timer u_timer2 (
      .clk_in(core_clk_in),
      .rst_n_in(rst_sync_n),
      .tif(tif2.chan)
   );

   // ==========================================================
   // APB decode
   assign idx = paddr_in[7:2];
   assign aligned = (paddr_in[1:0] == 2'b00);
   assign hit = aligned && index_known(idx);
   assign access = psel_in && penable_in;
   // Writes and read side effects land only on the completing edge
   assign wr_fire = access && pready_out && pwrite_in && hit;
   assign rd_fire = access && pready_out && !pwrite_in && hit;

   // Read multiplexer; counter bytes are live values
   always_comb begin
      rd_byte = 8'h00;
      case (idx)
         `RTB_IDX_RUN_CTRL: rd_byte = {1'b0, run_now, 4'h0};
         `RTB_IDX_T0_SETUP: rd_byte = setup_reg[0];
         `RTB_IDX_T0_RELOAD_HI: rd_byte = reload_hi[0];
         `RTB_IDX_T0_RELOAD_LO: rd_byte = reload_lo[0];
         `RTB_IDX_T0_COUNT_HI: rd_byte = count_v[0][15:8];
         `RTB_IDX_T0_COUNT_LO: rd_byte = count_v[0][7:0];
         `RTB_IDX_T1_SETUP: rd_byte = setup_reg[1];
         `RTB_IDX_T1_RELOAD_HI: rd_byte = reload_hi[1];
         `RTB_IDX_T1_RELOAD_LO: rd_byte = reload_lo[1];
         `RTB_IDX_T1_COUNT_HI: rd_byte = count_v[1][15:8];
         `RTB_IDX_T1_COUNT_LO: rd_byte = count_v[1][7:0];
         `RTB_IDX_T2_SETUP: rd_byte = setup_reg[2];
         `RTB_IDX_T2_RELOAD_HI: rd_byte = reload_hi[2];
         `RTB_IDX_T2_RELOAD_LO: rd_byte = reload_lo[2];
         `RTB_IDX_T2_COUNT_HI: rd_byte = count_v[2][15:8];
         `RTB_IDX_T2_COUNT_LO: rd_byte = count_v[2][7:0];
         `RTB_IDX_IRQ_STATUS: rd_byte = {5'h00, irq_status};
         `RTB_IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask};
         default: rd_byte = 8'h00;
      endcase
   end

   // Answer one cycle into the access phase so read data comes from a flop
   always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         apb_state <= rtb_pkg::RTB_APB_IDLE;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
      end else begin
         case (apb_state)
            rtb_pkg::RTB_APB_IDLE: begin
               if (access) begin
                  apb_state <= rtb_pkg::RTB_APB_ANSWER;
                  pready_out <= 1'b1;
                  pslverr_out <= !hit;
                  prdata_out <= (pwrite_in || !hit) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
               end
            end
            rtb_pkg::RTB_APB_ANSWER: begin
               apb_state <= rtb_pkg::RTB_APB_IDLE;
               pready_out <= 1'b0;
               pslverr_out <= 1'b0;
            end
            default: begin
               apb_state <= rtb_pkg::RTB_APB_IDLE;
               pready_out <= 1'b0;
               pslverr_out <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Run control: masked write of run bits
   always_comb begin
      sw_start_v = 3'b000;
      sw_stop_v = 3'b000;
      if (wr_fire && (idx == `RTB_IDX_RUN_CTRL)) begin
         for (int i = 0; i < 3; i++) begin
            if (pwdata_in[i]) begin
               sw_start_v[i] = pwdata_in[i + `RTB_RUN_SHIFT];
               sw_stop_v[i] = !pwdata_in[i + `RTB_RUN_SHIFT];
            end
         end
      end
   end

   // ==========================================================
   // Setup and reload registers; reserved bits always read zero
   always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int i = 0; i < 3; i++) begin
            setup_reg[i] <= `RTB_SETUP_RESET;
            reload_hi[i] <= `RTB_RELOAD_RESET;
            reload_lo[i] <= `RTB_RELOAD_RESET;
         end
      end else if (wr_fire) begin
         case (idx)
            `RTB_IDX_T0_SETUP: setup_reg[0] <= pwdata_in[7:0] & `RTB_SETUP_WMASK;
            `RTB_IDX_T0_RELOAD_HI: reload_hi[0] <= pwdata_in[7:0];
            `RTB_IDX_T0_RELOAD_LO: reload_lo[0] <= pwdata_in[7:0];
            `RTB_IDX_T1_SETUP: setup_reg[1] <= pwdata_in[7:0] & `RTB_SETUP_WMASK;
            `RTB_IDX_T1_RELOAD_HI: reload_hi[1] <= pwdata_in[7:0];
            `RTB_IDX_T1_RELOAD_LO: reload_lo[1] <= pwdata_in[7:0];
            `RTB_IDX_T2_SETUP: setup_reg[2] <= pwdata_in[7:0] & `RTB_SETUP_WMASK;
            `RTB_IDX_T2_RELOAD_HI: reload_hi[2] <= pwdata_in[7:0];
            `RTB_IDX_T2_RELOAD_LO: reload_lo[2] <= pwdata_in[7:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Interrupts
   // Only bits already shown to software are cleared, so late events survive
   always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         status_taken <= 3'b000;
      end else if (access && !pready_out) begin
         status_taken <= irq_status;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_status <= 3'b000;
      end else if (rd_fire && (idx == `RTB_IDX_IRQ_STATUS)) begin
         irq_status <= (irq_status & ~status_taken) | uflow;
      end else begin
         irq_status <= irq_status | uflow;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_mask <= `RTB_MASK_RESET;
      end else if (wr_fire && (idx == `RTB_IDX_IRQ_MASK)) begin
         irq_mask <= pwdata_in[2:0];
      end
   end

   // Level output, one cycle behind the status bits
   always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_status & irq_mask);
      end
   end
endmodule // rtb_top

`default_nettype wire
